// File: include/sdrc_regs.svh
// Register offsets, field positions, reset values and counts of the SDRAM controller
`ifndef SDRC_REGS_SVH
`define SDRC_REGS_SVH
// Protected block: word index 0..7 in 0x00..0x1C
`define SDRC_OFF_MR    8'h00
`define SDRC_OFF_TR    8'h04
`define SDRC_OFF_CR    8'h08
`define SDRC_OFF_TP0   8'h0C
`define SDRC_OFF_TP1   8'h10
`define SDRC_OFF_TP2   8'h14
`define SDRC_OFF_MD    8'h18
`define SDRC_OFF_HS    8'h1C
`define SDRC_PROT_END  8'h20
`define SDRC_OFF_LPR   8'h20
`define SDRC_OFF_WPMR  8'h24
`define SDRC_OFF_WPSR  8'h28
`define SDRC_OFF_STAT  8'h2C
// Low power register fields and codes
`define SDRC_LP_CMD    1:0
`define SDRC_LP_FRZ    2
`define SDRC_LP_OFF    2'h0
`define SDRC_LP_DEEP   2'h3
// Mode register field, normal mode code
`define SDRC_MR_MODE   2:0
`define SDRC_MODE_NORM 3'h0
// Configuration register fields
`define SDRC_CR_COL    1:0
`define SDRC_CR_ROW    3:2
`define SDRC_CR_DW16   4
`define SDRC_CR_ILV    5
`define SDRC_CR_CAS3   6
// Protection fields
`define SDRC_WP_EN     0
`define SDRC_WP_SRC    15:8
// Reset values
`define SDRC_REG_RST   32'h0000_0000
`define SDRC_LPR_RST   3'h0
// Beats per predicted end in an undefined-length burst
`define SDRC_UNDEF_BEATS 5'h04
`endif

// File: include/sdrc_pkg.sv
// Types shared by the SDRAM controller modules
package sdrc_pkg;
  typedef enum logic [2:0] {SDRC_IDLE, SDRC_OPEN, SDRC_CMD, SDRC_XFER, SDRC_FROZEN} sdrc_state_t;
  typedef enum logic [2:0] {SDRC_NOP, SDRC_PRE, SDRC_ACTV, SDRC_RD, SDRC_WR} sdrc_cmd_t;
  typedef enum logic [2:0] {SDRC_LPM_NONE, SDRC_LPM_SR, SDRC_LPM_PD, SDRC_LPM_DEEP,
                            SDRC_LPM_RESET} sdrc_lpm_t;
endpackage

// File: src/sdrc_rr_arb.sv
// Round-robin arbiter among the masters of the SDRAM controller
module sdrc_rr_arb #(
  parameter int NM = 4,
  localparam int IW = $clog2(NM)
) (
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic [NM-1:0] req,
  input  wire logic          take,
  input  wire logic [IW-1:0] takeIdx,
  output logic      [IW-1:0] pick,
  output logic               pickValid
);
  // Refuse a master count the index width cannot serve
  if (NM < 2 || NM > 16) begin : g_bad_nm
    $error("sdrc_rr_arb: NM out of range");
  end

  logic [IW-1:0] last; // Master granted most recently

  // Search starts just past the last granted master
  function automatic logic [IW:0] rrPick(input logic [NM-1:0] r, input logic [IW-1:0] l);
    logic [IW:0] res;
    logic [IW-1:0] j;
    res = '0;
    for (int i = NM; i >= 1; i--) begin
      j = IW'((int'(l) + i) % NM);
      if (r[j]) begin
        res = {1'b1, j};
      end
    end
    return res;
  endfunction

  assign {pickValid, pick} = rrPick(req, last);

  // Pointer at the top after reset, so master 0 wins a tie first
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      last <= IW'(NM - 1);
    end else if (take) begin
      last <= takeIdx;
    end else if (!pickValid) begin
      // Nobody waiting: a fresh tie must again start at master 0
      last <= IW'(NM - 1);
    end
  end
endmodule

// File: src/sdrc_lowpower_arb.sv
// SDRAM controller core: low-power freeze, multi-port arbitration, write protection
// Contract
// - Command 3 enters deep power-down and freezes
// - Command 3 plus freeze bit gives reset
// - Four masters; precharge/activate other bank early
// - Next read issued CAS latency early
// - Anticipated read beats higher-priority late requester
// - Round-robin, lowest number wins ties
// - Grant changes only at allowed cycles
// - Predicted end: length, or every four
// - Anticipated read may bend round-robin order
// - Protected registers ignore writes when enabled
// - Blocked write sets flag and source
// - Reading protection status clears the flag
// - Eight configuration registers are protected
// - Address split by config, 16/32-bit
// - Linear or interleaved bank mapping
// - Command codes: 0 none, 1, 2, 3
//
// Our own choices: the placing of the registers and register access over APB.
`include "sdrc_regs.svh"
module sdrc_lowpower_arb #(
  parameter int NM = 4,
  parameter int AW = 28,
  localparam int IW = $clog2(NM)
) (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NM-1:0]        mReq,
  input  wire logic [NM-1:0]        mWrite,
  input  wire logic [AW-1:0]        mAddr [NM],
  input  wire logic [4:0]           mLen [NM],
  output logic      [NM-1:0]        mGrant,
  output logic                      beatStrobe,
  output sdrc_pkg::sdrc_cmd_t       sdramCmd,
  output logic      [1:0]           sdramBank,
  output logic      [13:0]          sdramRow,
  output logic      [11:0]          sdramCol,
  output logic                      cke,
  output logic                      frozen,
  output sdrc_pkg::sdrc_lpm_t       lpMode
);
  // The mapping covers four banks and at most 28 address bits
  if (NM != 4 || AW < 16 || AW > 28) begin : g_bad_par
    $error("sdrc_lowpower_arb: NM must be 4 and AW 16..28");
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic [31:0]  prot [8];    // Mode, refresh, config, timing x3, device, speed
  logic [2:0]   lpReg;       // Low power command and freeze bit
  logic         protEn;      // Write protection on
  logic         violFlag;    // Blocked write seen
  logic [7:0]   violSrc;     // Word index of blocked register
  logic         heldOff;     // Frozen until reinitialized
  sdrc_pkg::sdrc_state_t state;
  logic [IW-1:0] cur;        // Master being served
  logic          curWrite;
  logic          curUndef;   // Undefined-length burst
  logic [1:0]    curBank;
  logic [13:0]   curRow;
  logic [4:0]    remain;     // Beats to predicted end
  logic          anticipated;
  logic [IW-1:0] antIdx;
  logic          prepStep;   // 0: precharge next, 1: activate next
  logic [13:0]   openRow [4];
  logic [3:0]    openValid;

  // Bank, row and column from a CPU address (bank 27:26, row 25:12, col 11:0)
  function automatic logic [27:0] mapAddr(input logic [AW-1:0] a, input logic [31:0] cr);
    logic [4:0] cb;
    logic [4:0] rb;
    logic [AW-1:0] w;
    logic [11:0] col;
    logic [13:0] row;
    logic [1:0] bk;
    cb = 5'h09 + 5'(cr[`SDRC_CR_COL]);
    rb = 5'h0B + 5'(cr[`SDRC_CR_ROW]);
    w = a >> (cr[`SDRC_CR_DW16] ? 1 : 2);
    col = 12'(w) & ((12'h001 << cb) - 12'h001);
    if (cr[`SDRC_CR_ILV]) begin
      bk = 2'(w >> cb);
      row = 14'(w >> (cb + 5'h02)) & ((14'h0001 << rb) - 14'h0001);
    end else begin
      row = 14'(w >> cb) & ((14'h0001 << rb) - 14'h0001);
      bk = 2'(w >> (cb + rb));
    end
    return {bk, row, col};
  endfunction

  // Offset falls in the protected block
  function automatic logic isProt(input logic [7:0] a);
    return a < `SDRC_PROT_END;
  endfunction

  function automatic logic [NM-1:0] oneHot(input logic [IW-1:0] i);
    return NM'(1) << i;
  endfunction

  // Bus phases: answer one cycle into the access phase, commit on completion
  logic acc;
  logic wrGo;
  logic rdGo;
  logic wrBlk;
  logic [31:0] cfg;
  logic [1:0] lpCmd;
  logic lpDeep;
  assign acc = psel & penable;
  assign wrGo = acc & pready & pwrite;
  assign rdGo = acc & pready & ~pwrite;
  assign wrBlk = wrGo & isProt(paddr) & protEn;
  assign cfg = prot[2];
  assign lpCmd = lpReg[`SDRC_LP_CMD];
  assign lpDeep = lpCmd == `SDRC_LP_DEEP;

  // Per-master mapping and open-row hit
  logic [27:0] mMap [NM];
  logic [NM-1:0] readHit;
  for (genvar g = 0; g < NM; g++) begin : g_map
    assign mMap[g] = mapAddr(mAddr[g], cfg);
    assign readHit[g] = mReq[g] & ~mWrite[g] & openValid[mMap[g][27:26]]
                      & (openRow[mMap[g][27:26]] == mMap[g][25:12]);
  end

  // Round-robin choice
  logic [IW-1:0] nxt;
  logic nxtValid;
  logic take;
  assign take = (state == sdrc_pkg::SDRC_IDLE && !heldOff && nxtValid)
              || (state == sdrc_pkg::SDRC_XFER && remain == 5'h01 && anticipated);
  sdrc_rr_arb #(.NM(NM)) u_arb (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .req       (mReq),
    .take      (take),
    .takeIdx   (state == sdrc_pkg::SDRC_IDLE ? nxt : antIdx),
    .pick      (nxt),
    .pickValid (nxtValid)
  );

  // Anticipation candidate: round-robin pick if it hits, else lowest hit other than the current master
  logic [IW-1:0] antPick;
  logic antValid;
  always_comb begin
    antPick = nxt;
    antValid = nxtValid & readHit[nxt];
    for (int i = NM - 1; i >= 0; i--) begin
      if (!antValid && readHit[i] && IW'(i) != cur) begin
        antPick = IW'(i);
      end
    end
    antValid = antValid | (|readHit);
  end

  logic endBeat;
  logic antFire;
  logic prepGo;
  logic freezeGo;
  logic [4:0] casLat;
  assign casLat = cfg[`SDRC_CR_CAS3] ? 5'h03 : 5'h02;
  assign endBeat = state == sdrc_pkg::SDRC_XFER && remain == 5'h01;
  assign antFire = state == sdrc_pkg::SDRC_XFER && !anticipated && !curWrite
                 && remain == casLat && antValid && antPick != cur;
  assign prepGo = state == sdrc_pkg::SDRC_XFER && !anticipated && nxtValid && nxt != cur
                && !readHit[nxt] && mMap[nxt][27:26] != curBank;
  assign freezeGo = lpDeep && state != sdrc_pkg::SDRC_FROZEN;

  // Register bus answer and read data
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `SDRC_REG_RST;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & (paddr[1:0] != 2'h0 || paddr > `SDRC_OFF_STAT);
      if (acc && !pready) begin
        if (isProt(paddr)) begin
          prdata <= prot[paddr[4:2]];
        end else if (paddr == `SDRC_OFF_LPR) begin
          prdata <= {29'h0000_0000, lpReg};
        end else if (paddr == `SDRC_OFF_WPMR) begin
          prdata <= {31'h0000_0000, protEn};
        end else if (paddr == `SDRC_OFF_WPSR) begin
          prdata <= {16'h0000, violSrc, 7'h00, violFlag};
        end else if (paddr == `SDRC_OFF_STAT) begin
          prdata <= {20'h0_0000, mGrant, 1'b0, 3'(state), 3'h0, heldOff}; // Shows engine state
        end else begin
          prdata <= `SDRC_REG_RST; // Unmapped reads as zero
        end
      end
    end
  end

  // Protected configuration storage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        prot[i] <= `SDRC_REG_RST;
      end
    end else if (wrGo && isProt(paddr) && !protEn) begin
      prot[paddr[4:2]] <= pwdata;
    end
  end

  // Protection enable, violation flag and source; a new violation beats the clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      protEn <= 1'b0;
      violFlag <= 1'b0;
      violSrc <= 8'h00;
    end else begin
      if (wrGo && paddr == `SDRC_OFF_WPMR) begin
        protEn <= pwdata[`SDRC_WP_EN];
      end
      if (wrBlk) begin
        violFlag <= 1'b1;
        violSrc <= {3'h0, paddr[6:2]};
      end else if (rdGo && paddr == `SDRC_OFF_WPSR) begin
        violFlag <= 1'b0;
      end
    end
  end

  // Low power command and reinitialization hold
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lpReg <= `SDRC_LPR_RST;
      heldOff <= 1'b0;
    end else begin
      if (wrGo && paddr == `SDRC_OFF_LPR) begin
        lpReg <= pwdata[2:0];
      end
      if (lpDeep) begin
        heldOff <= 1'b1;
      end else if (wrGo && paddr == `SDRC_OFF_MR && !wrBlk
                   && pwdata[`SDRC_MR_MODE] == `SDRC_MODE_NORM) begin
        heldOff <= 1'b0; // Return to normal closes reinitialization
      end
    end
  end

  // Low power status outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frozen <= 1'b0;
      cke <= 1'b1;
      lpMode <= sdrc_pkg::SDRC_LPM_NONE;
    end else begin
      frozen <= lpDeep | heldOff;
      cke <= !(lpDeep || (lpCmd != `SDRC_LP_OFF && state == sdrc_pkg::SDRC_IDLE && mReq == '0));
      if (lpDeep) begin
        lpMode <= lpReg[`SDRC_LP_FRZ] ? sdrc_pkg::SDRC_LPM_RESET
                                      : sdrc_pkg::SDRC_LPM_DEEP;
      end else begin
        lpMode <= sdrc_pkg::sdrc_lpm_t'({1'b0, lpCmd});
      end
    end
  end

  // Access engine: grant, commands, look-ahead
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= sdrc_pkg::SDRC_IDLE;
      mGrant <= '0;
      sdramCmd <= sdrc_pkg::SDRC_NOP;
      {sdramBank, sdramRow, sdramCol} <= 28'h000_0000;
      beatStrobe <= 1'b0;
      {cur, curWrite, curUndef, curBank, curRow} <= '0;
      remain <= 5'h00;
      anticipated <= 1'b0;
      antIdx <= '0;
      prepStep <= 1'b0;
      openValid <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        openRow[i] <= 14'h0000;
      end
    end else begin
      sdramCmd <= sdrc_pkg::SDRC_NOP;
      beatStrobe <= 1'b0;
      if (freezeGo) begin
        state <= sdrc_pkg::SDRC_FROZEN;
        mGrant <= '0;
        openValid <= 4'h0;
        anticipated <= 1'b0;
        prepStep <= 1'b0;
      end else begin
        unique case (state)
          sdrc_pkg::SDRC_IDLE: begin
            if (!heldOff && nxtValid) begin
              mGrant <= oneHot(nxt);
              cur <= nxt;
              curWrite <= mWrite[nxt];
              curUndef <= mLen[nxt] == 5'h00;
              remain <= mLen[nxt] == 5'h00 ? `SDRC_UNDEF_BEATS : mLen[nxt];
              {curBank, curRow} <= mMap[nxt][27:12];
              {sdramBank, sdramRow, sdramCol} <= mMap[nxt];
              if (openValid[mMap[nxt][27:26]] && openRow[mMap[nxt][27:26]] == mMap[nxt][25:12])
              begin
                state <= sdrc_pkg::SDRC_CMD; // Row already open
              end else begin
                sdramCmd <= sdrc_pkg::SDRC_PRE;
                openValid[mMap[nxt][27:26]] <= 1'b0;
                state <= sdrc_pkg::SDRC_OPEN;
              end
            end
          end
          sdrc_pkg::SDRC_OPEN: begin
            sdramCmd <= sdrc_pkg::SDRC_ACTV;
            openRow[curBank] <= curRow;
            openValid[curBank] <= 1'b1;
            state <= sdrc_pkg::SDRC_CMD;
          end
          sdrc_pkg::SDRC_CMD: begin
            sdramCmd <= curWrite ? sdrc_pkg::SDRC_WR : sdrc_pkg::SDRC_RD;
            beatStrobe <= 1'b1; // Strobe marks each transfer cycle while granted
            state <= sdrc_pkg::SDRC_XFER;
          end
          sdrc_pkg::SDRC_XFER: begin
            // Last beat shows with the grant, so a master can drop before re-arbitration
            beatStrobe <= !endBeat || anticipated;
            remain <= remain - 5'h01;
            if (antFire) begin
              sdramCmd <= sdrc_pkg::SDRC_RD;
              {sdramBank, sdramRow, sdramCol} <= mMap[antPick];
              anticipated <= 1'b1;
              antIdx <= antPick;
            end else if (prepGo) begin
              sdramCmd <= prepStep ? sdrc_pkg::SDRC_ACTV : sdrc_pkg::SDRC_PRE;
              {sdramBank, sdramRow, sdramCol} <= mMap[nxt];
              openValid[mMap[nxt][27:26]] <= prepStep;
              openRow[mMap[nxt][27:26]] <= mMap[nxt][25:12];
              prepStep <= ~prepStep;
            end
            if (endBeat) begin
              prepStep <= 1'b0;
              if (anticipated) begin
                // Read already issued: keep streaming, no priority override
                mGrant <= oneHot(antIdx);
                cur <= antIdx;
                curWrite <= 1'b0;
                curUndef <= mLen[antIdx] == 5'h00;
                remain <= mLen[antIdx] == 5'h00 ? `SDRC_UNDEF_BEATS : mLen[antIdx];
                {curBank, curRow} <= mMap[antIdx][27:12];
                anticipated <= 1'b0;
              end else begin
                mGrant <= '0;
                state <= sdrc_pkg::SDRC_IDLE;
              end
            end
          end
          sdrc_pkg::SDRC_FROZEN: begin
            if (!heldOff) begin
              state <= sdrc_pkg::SDRC_IDLE;
            end
          end
          default: state <= sdrc_pkg::SDRC_IDLE;
        endcase
      end
    end
  end

  freeze_entry_a: assert property (lpDeep |=> frozen && mGrant == '0)
    else $error("deep command did not freeze");
  reset_mode_a: assert property (lpDeep && lpReg[`SDRC_LP_FRZ] |=> lpMode == sdrc_pkg::SDRC_LPM_RESET)
    else $error("reset mode not shown");
  holdoff_grant_a: assert property (heldOff && state != sdrc_pkg::SDRC_XFER |=> mGrant == '0)
    else $error("grant while held off");
  ant_read_a: assert property (antFire |-> remain == casLat ##1 sdramCmd == sdrc_pkg::SDRC_RD)
    else $error("anticipated read misplaced");
  ant_keep_a: assert property (endBeat && anticipated |=> mGrant == oneHot($past(antIdx)))
    else $error("anticipated master not granted");
  rr_tie_a: assert property (state == sdrc_pkg::SDRC_IDLE && !heldOff && !lpDeep && mReq[0]
                             && u_arb.last == IW'(NM - 1) |=> mGrant == 4'h1)
    else $error("tie not won by master 0");
  grant_when_a: assert property ($changed(mGrant) |-> $past(state) == sdrc_pkg::SDRC_IDLE
                                 || $past(endBeat) || $past(freezeGo))
    else $error("grant changed mid burst");
  undef_len_a: assert property (state == sdrc_pkg::SDRC_XFER && curUndef |-> remain <= 5'h04)
    else $error("undefined burst past four beats");
  prot_block_a: assert property (wrBlk && paddr == `SDRC_OFF_CR |=> cfg == $past(cfg))
    else $error("protected write landed");
  viol_flag_a: assert property (wrBlk |=> violFlag && violSrc == {3'h0, $past(paddr[6:2])})
    else $error("violation not recorded");
  viol_clear_a: assert property (rdGo && paddr == `SDRC_OFF_WPSR && !wrBlk |=> !violFlag)
    else $error("status read did not clear flag");
  prep_pair_a: assert property (prepGo && !prepStep && !antFire && !endBeat
                                |=> sdramCmd == sdrc_pkg::SDRC_PRE)
    else $error("look-ahead precharge missing");
endmodule

// File: tb/sdrc_sdram_model.sv
// Behavioural model of the external SDRAM device watching the command bus
module sdrc_sdram_model (
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire sdrc_pkg::sdrc_cmd_t sdramCmd,
  input  wire logic [1:0]          sdramBank,
  input  wire logic                cke,
  output int                       protoErrors
);
  logic [3:0] rowOpen; // Open row flag per bank

  // Bank bookkeeping; a column command to a closed bank is a protocol slip
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rowOpen     <= 4'h0;
      protoErrors <= 0;
    end else if (!cke && sdramCmd != sdrc_pkg::SDRC_NOP) begin
      // Clock disabled: device ignores and must not get commands
      protoErrors <= protoErrors + 1;
    end else begin
      case (sdramCmd)
        sdrc_pkg::SDRC_PRE:  rowOpen[sdramBank] <= 1'b0;
        sdrc_pkg::SDRC_ACTV: rowOpen[sdramBank] <= 1'b1;
        sdrc_pkg::SDRC_RD, sdrc_pkg::SDRC_WR: begin
          // Row must be active before a read or write
          if (!rowOpen[sdramBank]) protoErrors <= protoErrors + 1;
        end
        default: ;
      endcase
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the SDRAM controller core
`include "sdrc_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                ref_clk = 1'b0;  // 20 MHz clock
  logic                resetn  = 1'b0;  // Async reset, low active
  logic [7:0]          paddr   = 8'h00;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [31:0]         pwdata  = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [3:0]          mReq    = 4'h0;  // Master requests
  logic [3:0]          mWrite  = 4'h0;
  logic [27:0]         mAddr [4] = '{default: 28'h000_0000};
  logic [4:0]          mLen [4]  = '{default: 5'h01};
  logic [3:0]          mGrant;
  logic                beatStrobe;
  sdrc_pkg::sdrc_cmd_t sdramCmd;
  logic [1:0]          sdramBank;
  logic [13:0]         sdramRow;
  logic [11:0]         sdramCol;
  logic                cke;
  logic                frozen;
  sdrc_pkg::sdrc_lpm_t lpMode;
  int                  protoErrors;
  int                  num_errors = 0;
  int                  checked = 0;
  int                  beats [4];       // Beats seen per master
  int                  order [$];       // Masters in order of first beat
  logic                preInBeat;       // Precharge issued while beats run
  logic                rdInBeat;        // Read issued while beats run
  logic [27:0]         rdSpot;          // Bank, row, column at last read
  logic [31:0]         v;
  logic                e;

  sdrc_lowpower_arb dut (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mReq(mReq), .mWrite(mWrite), .mAddr(mAddr), .mLen(mLen),
    .mGrant(mGrant), .beatStrobe(beatStrobe), .sdramCmd(sdramCmd), .sdramBank(sdramBank),
    .sdramRow(sdramRow), .sdramCol(sdramCol), .cke(cke), .frozen(frozen), .lpMode(lpMode));
  sdrc_sdram_model mem (.ref_clk(ref_clk), .resetn(resetn), .sdramCmd(sdramCmd),
    .sdramBank(sdramBank), .cke(cke), .protoErrors(protoErrors));

  // Free running clock
  always #25 ref_clk = ~ref_clk;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
  endtask

  // Serve the masters in mask; each drops its request after its last beat
  task automatic serve(input logic [3:0] mask, input logic [4:0] len);
    int lim;
    int tail;
    int g;
    lim = (len == 5'h00) ? 4 : int'(len);
    beats = '{default: 0};
    order.delete();
    preInBeat = 1'b0;
    rdInBeat = 1'b0;
    tail = 0;
    for (int i = 0; i < 4; i++) mLen[i] <= len;
    @(posedge ref_clk);
    mReq <= mask;
    // Tail cycles catch beats that run past the expected length
    while (tail < 4) begin
      @(posedge ref_clk);
      if (mReq === 4'h0) tail++;
      if (sdramCmd === sdrc_pkg::SDRC_RD) rdSpot = {sdramBank, sdramRow, sdramCol};
      if (beatStrobe === 1'b1) begin
        g = 0;
        for (int i = 0; i < 4; i++) if (mGrant[i] === 1'b1) g = i;
        if (beats[g] == 0) order.push_back(g);
        beats[g]++;
        if (beats[g] == lim) mReq[g] <= 1'b0;
        if (sdramCmd === sdrc_pkg::SDRC_PRE) preInBeat = 1'b1;
        if (sdramCmd === sdrc_pkg::SDRC_RD) rdInBeat = 1'b1;
      end
    end
  endtask

  // Reset values and an unmapped offset
  task automatic t_regs();
    apb(1'b0, 8'h30, 32'h0, v, e);
    check(v, 32'h0000_0000);
    check({31'h0000_0000, e}, 32'h0000_0001);
    apb(1'b0, `SDRC_OFF_CR, 32'h0, v, e);
    check(v, `SDRC_REG_RST);
    apb(1'b0, `SDRC_OFF_LPR, 32'h0, v, e);
    check(v, 0);
  endtask

  // Every protected register refuses writes, flags and names itself
  task automatic t_protect();
    wr(`SDRC_OFF_WPMR, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      wr(8'(i * 4), 32'h0000_005A);
      apb(1'b0, 8'(i * 4), 32'h0, v, e);
      check(v, 0);
      apb(1'b0, `SDRC_OFF_WPSR, 32'h0, v, e);
      check(v & 32'h0000_FF01, {16'h0000, 8'(i), 8'h01});
      apb(1'b0, `SDRC_OFF_WPSR, 32'h0, v, e);
      check(v & 32'h0000_0001, 0);
    end
    wr(`SDRC_OFF_WPMR, 32'h0000_0000);
    wr(`SDRC_OFF_CR, 32'h0000_0010);
    apb(1'b0, `SDRC_OFF_CR, 32'h0, v, e);
    check(v, 32'h0000_0010);
  endtask

  // 16-bit width: linear split of one address, then interleaved split of a second address
  task automatic t_map();
    mAddr[2] <= {5'h00, 2'h2, 11'h2A5, 9'h1C3, 1'b0};
    serve(4'b0100, 5'h01);
    check(rdSpot, {2'h2, 14'h02A5, 12'h1C3});
    wr(`SDRC_OFF_CR, 32'h0000_0030);
    mAddr[2] <= {5'h00, 11'h2A5, 2'h1, 9'h1C3, 1'b0};
    serve(4'b0100, 5'h01);
    check(rdSpot, {2'h1, 14'h02A5, 12'h1C3});
    wr(`SDRC_OFF_CR, 32'h0000_0010);
  endtask

  // Four simultaneous singles, one a write: lowest first, then round-robin
  task automatic t_arb();
    for (int i = 0; i < 4; i++) mAddr[i] <= 28'(i) << 21;
    mWrite <= 4'b1000;
    serve(4'hF, 5'h01);
    mWrite <= 4'b0000;
    check(order.size(), 4);
    for (int i = 0; i < 4; i++) check(order[i], i);
  endtask

  // Burst lengths and look-ahead commands
  task automatic t_burst();
    serve(4'b0001, 5'h00);
    check(beats[0], 4);
    serve(4'b0001, 5'h03);
    check(beats[0], 3);
    mAddr[1] <= (28'h1 << 21) | (28'h5 << 10);
    serve(4'b0011, 5'h08);
    check(beats[0], 8);
    check(beats[1], 8);
    check(preInBeat, 1'b1);
    serve(4'b0011, 5'h08);
    check(rdInBeat, 1'b1);
  endtask

  // Low-power codes, deep power-down, reset mode and their exits
  task automatic t_freeze();
    for (int c = 1; c < 3; c++) begin
      wr(`SDRC_OFF_LPR, 32'(c));
      repeat (2) @(posedge ref_clk);
      check({27'h000_0000, frozen, cke, lpMode}, c);
      wr(`SDRC_OFF_LPR, 32'h0);
    end
    // No access in flight before the freeze
    check(mReq, 0);
    wr(`SDRC_OFF_LPR, 32'h0000_0003);
    repeat (2) @(posedge ref_clk);
    check({frozen, cke, lpMode}, {2'b10, sdrc_pkg::SDRC_LPM_DEEP});
    mReq <= 4'b0001;
    repeat (10) @(posedge ref_clk);
    check(mGrant, 0);
    apb(1'b0, `SDRC_OFF_STAT, 32'h0, v, e);
    check(v, {25'h000_0000, 3'(sdrc_pkg::SDRC_FROZEN), 3'h0, 1'b1});
    wr(`SDRC_OFF_LPR, 32'h0);
    check(frozen, 1'b1);
    // Held request withdrawn so the next scenario starts from a clean idle
    mReq <= 4'h0;
    wr(`SDRC_OFF_MR, 32'h0);
    repeat (2) @(posedge ref_clk);
    check(frozen, 1'b0);
    serve(4'b0001, 5'h01);
    check(beats[0], 1);
    wr(`SDRC_OFF_LPR, 32'h0000_0007);
    repeat (2) @(posedge ref_clk);
    check({frozen, lpMode}, {1'b1, sdrc_pkg::SDRC_LPM_RESET});
    wr(`SDRC_OFF_LPR, 32'h0);
    wr(`SDRC_OFF_MR, 32'h0);
    repeat (2) @(posedge ref_clk);
    check(frozen, 1'b0);
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_protect();
    t_map();
    t_arb();
    t_burst();
    t_freeze();
    check(protoErrors, 0);
    print_verdict();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #1_000_000;
    num_errors++;
    print_verdict();
  end
endmodule
